// file: irq_src_defs.vh
`ifndef IRQ_SRC_DEFS_VH
`define IRQ_SRC_DEFS_VH
// Register byte addresses
`define ADDR_CTRL_MAIN 8'h00
`define ADDR_CTRL_SECOND 8'h04
`define ADDR_CTRL_THIRD 8'h08
`define ADDR_RESET_CAUSE 8'h0C
`define ADDR_TIMER_CTRL 8'h10
`define ADDR_TIMER_LOW 8'h14
`define ADDR_TIMER_HIGH 8'h18
// Main control fields
`define MAIN_GIE 7
`define MAIN_GIEL 6
`define MAIN_TMR_EN 5
`define MAIN_EXT0_EN 4
`define MAIN_CHG_EN 3
`define MAIN_TMR_FLAG 2
`define MAIN_EXT0_FLAG 1
`define MAIN_CHG_FLAG 0
// Second control fields
`define SEC_EDGE0 6
`define SEC_EDGE3 3
`define SEC_TMR_PRIO 2
`define SEC_EXT3_PRIO 1
`define SEC_CHG_PRIO 0
// Third control fields
`define THR_EXT2_PRIO 7
`define THR_EXT1_PRIO 6
`define THR_EN_LSB 3
`define THR_FLAG_LSB 0
// Reset cause fields
`define RC_PRIO_EN 7
`define RC_RI 4
`define RC_TO 3
`define RC_PD 2
`define RC_POR 1
`define RC_BOR 0
// Timer control fields
`define TC_RUN 7
`define TC_MODE8 6
// Reset values
`define RST_CTRL_MAIN 8'h00
`define RST_CTRL_SECOND 8'h7F
`define RST_CTRL_THIRD 8'hC0
`define RST_RESET_CAUSE 8'h1C
`define RST_TIMER_CTRL 8'h40
// Context store sizes
`define PC_WIDTH 21
`define STACK_DEPTH 31
`define SP_WIDTH 5
`define SP_FULL 5'h1F
`endif

// file: timer_overflow.v
`timescale 1ns/10ps
`include "irq_src_defs.vh"
// Free-running 8/16-bit counter with one-cycle overflow pulse
module timer_overflow (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Control
    input wire run,
    input wire mode8,
    input wire wr_low,
    input wire wr_high,
    input wire [7:0] wdata,
    // Status
    output reg [15:0] count_q,
    output reg ovf_q
);
    // Counting and rollover detection
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 16'h0000;
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (wr_low) begin
                count_q[7:0] <= wdata;
            end else if (wr_high) begin
                count_q[15:8] <= wdata;
            end else if (run) begin
                if (mode8) begin
                    count_q[7:0] <= count_q[7:0] + 8'h01;
                    ovf_q <= (count_q[7:0] == 8'hFF);
                end else begin
                    count_q <= count_q + 16'h0001;
                    ovf_q <= (count_q == 16'hFFFF);
                end
            end
        end
    end
endmodule // timer_overflow

// file: context_store.v
`timescale 1ns/10ps
`include "irq_src_defs.vh"
// Return address stack plus fast-return shadow registers
module context_store (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Entry and return
    input wire push,
    input wire pop,
    input wire [`PC_WIDTH-1:0] pc_in,
    input wire [7:0] working_register_in,
    input wire [7:0] status_in,
    input wire [7:0] bsr_in,
    // Registered outputs
    output reg [`PC_WIDTH-1:0] pc_out_q,
    output reg [7:0] working_register_q,
    output reg [7:0] status_q,
    output reg [7:0] bsr_q,
    output reg full_q
);
    reg [`PC_WIDTH-1:0] mem [0:`STACK_DEPTH-1];
    reg [`SP_WIDTH-1:0] sp_q;
    // Memory write on push
    always @(posedge clk) begin
        if (push && sp_q != `SP_FULL) begin
            mem[sp_q] <= pc_in;
        end
    end
    // Pointer, read register and shadow copies
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sp_q <= 5'h00;
            pc_out_q <= 21'h000000;
            working_register_q <= 8'h00;
            status_q <= 8'h00;
            bsr_q <= 8'h00;
            full_q <= 1'b0;
        end else if (push) begin
            if (sp_q != `SP_FULL) begin
                sp_q <= sp_q + 5'h01;
            end
            full_q <= (sp_q >= `SP_FULL - 5'h01);
            working_register_q <= working_register_in;
            status_q <= status_in;
            bsr_q <= bsr_in;
        end else if (pop && sp_q != 5'h00) begin
            sp_q <= sp_q - 5'h01;
            pc_out_q <= mem[sp_q - 5'h01];
            full_q <= 1'b0;
        end
    end
endmodule // context_store

// file: irq_sources.v
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "irq_src_defs.vh"
module irq_sources (
    // Clock and reset
    input wire CLK,
    input wire RESETN,
    // Avalon-MM slave
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // External interrupt and change pins
    input wire [3:0] EXT_PIN,
    input wire [3:0] CHANGE_PIN,
    // Reset cause events from the core
    input wire RESET_INSTR_EVT,
    input wire WDT_TIMEOUT_EVT,
    input wire SLEEP_EVT,
    input wire WDT_CLEAR_EVT,
    input wire BROWNOUT_EVT,
    // Core handshake
    input wire CORE_ASLEEP,
    input wire CORE_ENTRY,
    input wire CORE_ENTRY_HIGH,
    input wire CORE_FAST_RETURN,
    input wire [20:0] CORE_PC,
    input wire [7:0] CORE_WORKING_REGISTER,
    input wire [7:0] CORE_STATUS,
    input wire [7:0] CORE_BSR,
    // Requests to the core
    output reg IRQ_HIGH,
    output reg IRQ_LOW,
    output reg WAKE,
    // Context restore values
    output wire [20:0] RETURN_PC,
    output wire [7:0] SHADOW_WORKING_REGISTER,
    output wire [7:0] SHADOW_STATUS,
    output wire [7:0] SHADOW_BSR,
    output wire STACK_FULL
);
    reg [7:0] main_q, main_d;
    reg [7:0] second_q;
    reg [7:0] third_q, third_d;
    reg [7:0] cause_q, cause_d;
    reg [7:0] tctrl_q;
    reg [3:0] ext_prev_q;
    reg [3:0] chg_prev_q;
    reg [3:0] ext_edge;
    reg [3:0] ext_flag;
    reg [3:0] ext_en;
    reg [3:0] ext_prio;
    reg [31:0] rdata;
    wire req_ok;
    wire wr_ok;
    wire [15:0] tcount;
    wire tovf;
    wire chg_event;
    wire tmr_req;
    wire chg_req;
    wire [3:0] ext_req;
    reg any_high, any_low;
    integer i;
    integer j;
    integer k;

    // Byte write to the low lane of a matched register
    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        input be0;
        begin
            wr_hit = wr & be0 & (addr == target);
        end
    endfunction

    // Edge detector honouring the edge select
    function edge_seen;
        input prev;
        input cur;
        input rising;
        begin
            edge_seen = rising ? (~prev & cur) : (prev & ~cur);
        end
    endfunction

    // Bus access completes when waitrequest is low
    assign req_ok = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
    assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;

    // Timer instance
    timer_overflow u_timer (
        .clk(CLK),
        .resetn(RESETN),
        .run(tctrl_q[`TC_RUN]),
        .mode8(tctrl_q[`TC_MODE8]),
        .wr_low(wr_hit(AVS_ADDRESS, `ADDR_TIMER_LOW, wr_ok,
            AVS_BYTEENABLE[0])),
        .wr_high(wr_hit(AVS_ADDRESS, `ADDR_TIMER_HIGH, wr_ok,
            AVS_BYTEENABLE[0])),
        .wdata(AVS_WRITEDATA[7:0]),
        .count_q(tcount),
        .ovf_q(tovf)
    );

    // Context store instance
    context_store u_ctx (
        .clk(CLK),
        .resetn(RESETN),
        .push(CORE_ENTRY),
        .pop(CORE_FAST_RETURN),
        .pc_in(CORE_PC),
        .working_register_in(CORE_WORKING_REGISTER),
        .status_in(CORE_STATUS),
        .bsr_in(CORE_BSR),
        .pc_out_q(RETURN_PC),
        .working_register_q(SHADOW_WORKING_REGISTER),
        .status_q(SHADOW_STATUS),
        .bsr_q(SHADOW_BSR),
        .full_q(STACK_FULL)
    );

    // External pin edges, per-pin flag, enable and priority
    always @* begin
        ext_flag = {third_q[2:0], main_q[`MAIN_EXT0_FLAG]};
        ext_en = {third_q[5:3], main_q[`MAIN_EXT0_EN]};
        ext_prio = {second_q[`SEC_EXT3_PRIO], third_q[`THR_EXT2_PRIO],
            third_q[`THR_EXT1_PRIO], 1'b1};
        for (i = 0; i < 4; i = i + 1) begin
            ext_edge[i] = edge_seen(ext_prev_q[i], EXT_PIN[i],
                second_q[`SEC_EDGE0 - i]);
        end
    end

    // Any change on upper port pins
    assign chg_event = |(chg_prev_q ^ CHANGE_PIN);

    // Flag and enable form each request
    assign ext_req = ext_flag & ext_en;
    assign tmr_req = main_q[`MAIN_TMR_FLAG] & main_q[`MAIN_TMR_EN];
    assign chg_req = main_q[`MAIN_CHG_FLAG] & main_q[`MAIN_CHG_EN];

    always @* begin
        any_high = ext_req[0];
        any_low = 1'b0;
        for (j = 1; j < 4; j = j + 1) begin
            if (ext_prio[j]) begin
                any_high = any_high | ext_req[j];
            end else begin
                any_low = any_low | ext_req[j];
            end
        end
        if (second_q[`SEC_TMR_PRIO]) begin
            any_high = any_high | tmr_req;
        end else begin
            any_low = any_low | tmr_req;
        end
        if (second_q[`SEC_CHG_PRIO]) begin
            any_high = any_high | chg_req;
        end else begin
            any_low = any_low | chg_req;
        end
    end

    // Next main control: events set, software writes, set wins
    always @* begin
        main_d = main_q;
        if (wr_hit(AVS_ADDRESS, `ADDR_CTRL_MAIN, wr_ok,
            AVS_BYTEENABLE[0])) begin
            main_d = AVS_WRITEDATA[7:0];
        end
        // Entry masks further requests of that level
        if (CORE_ENTRY) begin
            if (CORE_ENTRY_HIGH || !cause_q[`RC_PRIO_EN]) begin
                main_d[`MAIN_GIE] = 1'b0;
            end else begin
                main_d[`MAIN_GIEL] = 1'b0;
            end
        end
        if (ext_edge[0]) begin
            main_d[`MAIN_EXT0_FLAG] = 1'b1;
        end
        if (tovf) begin
            main_d[`MAIN_TMR_FLAG] = 1'b1;
        end
        if (chg_event) begin
            main_d[`MAIN_CHG_FLAG] = 1'b1;
        end
    end

    // Next third control: flags of externals 1 to 3
    always @* begin
        third_d = third_q;
        if (wr_hit(AVS_ADDRESS, `ADDR_CTRL_THIRD, wr_ok,
            AVS_BYTEENABLE[0])) begin
            third_d = AVS_WRITEDATA[7:0];
        end
        // Edge sets flag, wins over clear
        for (k = 1; k < 4; k = k + 1) begin
            if (ext_edge[k]) begin
                third_d[`THR_FLAG_LSB + k - 1] = 1'b1;
            end
        end
    end

    // Next reset cause: software writes, hardware events win
    always @* begin
        cause_d = cause_q;
        if (wr_hit(AVS_ADDRESS, `ADDR_RESET_CAUSE, wr_ok,
            AVS_BYTEENABLE[0])) begin
            cause_d[`RC_PRIO_EN] = AVS_WRITEDATA[`RC_PRIO_EN];
            cause_d[`RC_RI] = AVS_WRITEDATA[`RC_RI];
            cause_d[`RC_POR] = AVS_WRITEDATA[`RC_POR];
            cause_d[`RC_BOR] = AVS_WRITEDATA[`RC_BOR];
        end
        // Reset cause flags from core events
        if (RESET_INSTR_EVT) begin
            cause_d[`RC_RI] = 1'b0;
        end
        if (WDT_CLEAR_EVT) begin
            cause_d[`RC_TO] = 1'b1;
            cause_d[`RC_PD] = 1'b1;
        end
        if (SLEEP_EVT) begin
            cause_d[`RC_TO] = 1'b1;
            cause_d[`RC_PD] = 1'b0;
        end
        if (WDT_TIMEOUT_EVT) begin
            cause_d[`RC_TO] = 1'b0;
        end
        if (BROWNOUT_EVT) begin
            cause_d[`RC_BOR] = 1'b0;
        end
        cause_d[6:5] = 2'b00;
    end

    // Read mux, unmapped addresses read zero
    always @* begin
        rdata = 32'h00000000;
        case (AVS_ADDRESS)
            `ADDR_CTRL_MAIN: rdata[7:0] = main_q;
            `ADDR_CTRL_SECOND: rdata[7:0] = second_q;
            `ADDR_CTRL_THIRD: rdata[7:0] = third_q;
            `ADDR_RESET_CAUSE: rdata[7:0] = cause_q & 8'h9F;
            `ADDR_TIMER_CTRL: rdata[7:0] = tctrl_q;
            `ADDR_TIMER_LOW: rdata[7:0] = tcount[7:0];
            `ADDR_TIMER_HIGH: rdata[7:0] = tcount[15:8];
            default: rdata = 32'h00000000;
        endcase
    end

    // Register state and pin history
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            main_q <= `RST_CTRL_MAIN;
            second_q <= `RST_CTRL_SECOND;
            third_q <= `RST_CTRL_THIRD;
            cause_q <= `RST_RESET_CAUSE;
            tctrl_q <= `RST_TIMER_CTRL;
            ext_prev_q <= 4'h0;
            chg_prev_q <= 4'h0;
        end else begin
            main_q <= main_d;
            third_q <= third_d;
            cause_q <= cause_d;
            if (wr_hit(AVS_ADDRESS, `ADDR_CTRL_SECOND, wr_ok,
                AVS_BYTEENABLE[0])) begin
                second_q <= AVS_WRITEDATA[7:0] & 8'h7F;
            end
            if (wr_hit(AVS_ADDRESS, `ADDR_TIMER_CTRL, wr_ok,
                AVS_BYTEENABLE[0])) begin
                tctrl_q <= AVS_WRITEDATA[7:0] & 8'hC0;
            end
            ext_prev_q <= EXT_PIN;
            chg_prev_q <= CHANGE_PIN;
        end
    end

    // Avalon handshake: one wait cycle, data registered
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            if ((AVS_READ | AVS_WRITE) && AVS_WAITREQUEST) begin
                AVS_WAITREQUEST <= 1'b0;
                AVS_READDATA <= rdata;
            end else begin
                AVS_WAITREQUEST <= 1'b1;
            end
        end
    end

    // Core request outputs
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ_HIGH <= 1'b0;
            IRQ_LOW <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            // Any enabled external, timer or change flag wakes a sleeping core
            WAKE <= CORE_ASLEEP & (|ext_req | tmr_req | chg_req);
            if (cause_q[`RC_PRIO_EN]) begin
                IRQ_HIGH <= main_q[`MAIN_GIE] & any_high;
                IRQ_LOW <= main_q[`MAIN_GIE] & main_q[`MAIN_GIEL]
                    & any_low;
            end else begin
                IRQ_HIGH <= main_q[`MAIN_GIE] & (any_high | any_low);
                IRQ_LOW <= 1'b0;
            end
        end
    end
endmodule // irq_sources

// file: irq_sources_properties.sv
`timescale 1ns/10ps
`include "irq_src_defs.vh"
// Port-level checks for the interrupt source block
module irq_sources_checker (
    // Clock and reset
    input wire CLK,
    input wire RESETN,
    // Register bus
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    // Core link
    input wire CORE_ASLEEP,
    input wire CORE_ENTRY,
    input wire CORE_FAST_RETURN,
    input wire [20:0] CORE_PC,
    input wire [7:0] CORE_WORKING_REGISTER,
    input wire [7:0] CORE_STATUS,
    input wire [7:0] CORE_BSR,
    input wire WAKE,
    input wire [20:0] RETURN_PC,
    input wire [7:0] SHADOW_WORKING_REGISTER,
    input wire [7:0] SHADOW_STATUS,
    input wire [7:0] SHADOW_BSR,
    input wire STACK_FULL
);
    reg [5:0] depth_q;
    wire rd_done;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Read data valid where the wait drops
    assign rd_done = AVS_READ && !AVS_WAITREQUEST;
    // Entries held on the return stack; entry wins over return
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            depth_q <= 6'h00;
        end else if (CORE_ENTRY) begin
            if (depth_q != 6'h1F) begin
                depth_q <= depth_q + 6'h01;
            end
        end else if (CORE_FAST_RETURN && depth_q != 6'h00) begin
            depth_q <= depth_q - 6'h01;
        end
    end
    chk_bus_one_wait: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer not after one wait");
    chk_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("wait low longer than one cycle");
    chk_cause_resv_zero: assert property (
        rd_done && AVS_ADDRESS == `ADDR_RESET_CAUSE |-> !AVS_READDATA[6:5])
        else $error("reserved cause bits not zero");
    chk_unmapped_zero: assert property (
        rd_done && AVS_ADDRESS > `ADDR_TIMER_HIGH |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_wake_asleep: assert property (WAKE |-> $past(CORE_ASLEEP))
        else $error("wake while core awake");
    chk_shadow_copy: assert property (
        CORE_ENTRY && !STACK_FULL |=> SHADOW_WORKING_REGISTER == $past(CORE_WORKING_REGISTER)
        && SHADOW_STATUS == $past(CORE_STATUS)
        && SHADOW_BSR == $past(CORE_BSR))
        else $error("shadow copy wrong");
    chk_return_pc: assert property (
        CORE_ENTRY && !STACK_FULL ##1 CORE_FAST_RETURN && !CORE_ENTRY
        |=> RETURN_PC == $past(CORE_PC, 2))
        else $error("return address wrong");
    chk_stack_full: assert property (
        STACK_FULL == (depth_q == 6'h1F))
        else $error("stack full flag wrong");
    cover property (CORE_ENTRY ##1 CORE_FAST_RETURN);
    cover property (WAKE);
    cover property (STACK_FULL && CORE_ENTRY);
endmodule // irq_sources_checker

bind irq_sources irq_sources_checker irq_sources_checker_inst (.CLK, .RESETN,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
    .CORE_ASLEEP, .CORE_ENTRY, .CORE_FAST_RETURN, .CORE_PC, .CORE_WORKING_REGISTER,
    .CORE_STATUS, .CORE_BSR, .WAKE, .RETURN_PC, .SHADOW_WORKING_REGISTER, .SHADOW_STATUS,
    .SHADOW_BSR, .STACK_FULL);

// file: core_model.sv
`timescale 1ns/10ps
// Processor core stand-in: vectors on requests, optional fast return
module core_model (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Requests and bench controls
    input wire irq_high,
    input wire irq_low,
    input wire sleep_req,
    input wire fast_mode,
    // Core outputs
    output reg entry_q,
    output reg entry_high_q,
    output reg fast_ret_q,
    output reg [20:0] pc_q,
    output wire [7:0] working_register,
    output wire [7:0] status,
    output wire [7:0] bank_select_register,
    output reg asleep_q
);
    reg busy_q;
    // Register contents follow the running address
    assign working_register = pc_q[7:0];
    assign status = pc_q[12:5];
    assign bank_select_register = ~pc_q[7:0];
    // Execution, vectoring and return
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            entry_q <= 1'b0;
            entry_high_q <= 1'b0;
            fast_ret_q <= 1'b0;
            pc_q <= 21'h0;
            asleep_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            pc_q <= pc_q + 21'h3;
            asleep_q <= sleep_req;
            entry_q <= (irq_high || irq_low) && !busy_q && !entry_q
                && !asleep_q;
            entry_high_q <= irq_high;
            busy_q <= entry_q || (busy_q && (irq_high || irq_low));
            // Slow path keeps its own copies
            fast_ret_q <= entry_q && fast_mode;
        end
    end
endmodule // core_model

// file: irq_sources_tb_top.sv
`timescale 1ns/10ps
`include "irq_src_defs.vh"
// Sequence bench for the interrupt source block
module irq_sources_tb_top;
    reg CLK = 1'b0;
    reg RESETN = 1'b0;
    reg [7:0] AVS_ADDRESS = 8'h00;
    reg AVS_READ = 1'b0;
    reg AVS_WRITE = 1'b0;
    reg [31:0] AVS_WRITEDATA = 32'h0;
    reg [3:0] AVS_BYTEENABLE = 4'hF;
    reg [3:0] EXT_PIN = 4'h0;
    reg [3:0] CHANGE_PIN = 4'h0;
    reg [4:0] ev = 5'h00;
    reg sleep = 1'b1;
    reg fast = 1'b1;
    reg [31:0] rdat;
    reg [20:0] psave;
    reg [7:0] wsave, en, sec, thr, fl, ra, bv;
    reg [2:0] ex;
    wire [31:0] AVS_READDATA;
    wire [20:0] CORE_PC, RETURN_PC;
    wire [7:0] CORE_WORKING_REGISTER, CORE_STATUS, CORE_BSR;
    wire [7:0] SHADOW_WORKING_REGISTER, SHADOW_STATUS, SHADOW_BSR;
    wire AVS_WAITREQUEST, IRQ_HIGH, IRQ_LOW, WAKE, STACK_FULL;
    wire CORE_ENTRY, CORE_ENTRY_HIGH, CORE_FAST_RETURN, CORE_ASLEEP;
    int miscompares = 0, samples_checked = 0, cyc = 0, ent_n = 0;
    int i, p, n, e0;
    irq_sources irq_sources_inst (.CLK, .RESETN, .AVS_ADDRESS, .AVS_READ,
        .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
        .AVS_WAITREQUEST, .EXT_PIN, .CHANGE_PIN, .RESET_INSTR_EVT(ev[0]),
        .WDT_TIMEOUT_EVT(ev[1]), .SLEEP_EVT(ev[2]), .WDT_CLEAR_EVT(ev[3]),
        .BROWNOUT_EVT(ev[4]), .CORE_ASLEEP, .CORE_ENTRY, .CORE_ENTRY_HIGH,
        .CORE_FAST_RETURN, .CORE_PC, .CORE_WORKING_REGISTER, .CORE_STATUS, .CORE_BSR,
        .IRQ_HIGH, .IRQ_LOW, .WAKE, .RETURN_PC, .SHADOW_WORKING_REGISTER, .SHADOW_STATUS,
        .SHADOW_BSR, .STACK_FULL);
    core_model core_model_inst (.clk(CLK), .resetn(RESETN),
        .irq_high(IRQ_HIGH), .irq_low(IRQ_LOW), .sleep_req(sleep),
        .fast_mode(fast),
        .entry_q(CORE_ENTRY), .entry_high_q(CORE_ENTRY_HIGH),
        .fast_ret_q(CORE_FAST_RETURN), .pc_q(CORE_PC), .working_register(CORE_WORKING_REGISTER),
        .status(CORE_STATUS), .bank_select_register(CORE_BSR), .asleep_q(CORE_ASLEEP));
    // Clock
    always #20 CLK = ~CLK;
    // Entry log and hang ceiling
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (CORE_ENTRY === 1'b1) begin
            ent_n <= ent_n + 1;
            wsave <= CORE_WORKING_REGISTER;
            psave <= CORE_PC;
        end
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycle held until the wait drops
    task bus(input w, input [7:0] a, input [7:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= w;
        AVS_READ <= !w;
        @(posedge CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
        rdat = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdat, {24'h0, e});
    endtask
    task pulse(input [4:0] m);
        ev <= m;
        @(posedge CLK);
        ev <= 5'h00;
        @(posedge CLK);
    endtask
    // Request lines as high, low, wake
    task irq(input [2:0] e);
        repeat (4) @(posedge CLK);
        chk({29'h0, IRQ_HIGH, IRQ_LOW, WAKE}, {29'h0, e});
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        // Reset values and unmapped places
        rd(`ADDR_CTRL_MAIN, `RST_CTRL_MAIN);
        rd(`ADDR_CTRL_SECOND, `RST_CTRL_SECOND);
        rd(`ADDR_CTRL_THIRD, `RST_CTRL_THIRD);
        rd(`ADDR_RESET_CAUSE, `RST_RESET_CAUSE);
        rd(`ADDR_TIMER_CTRL, `RST_TIMER_CTRL);
        rd(8'h1C, 8'h00);
        $display("reset test done");
        // Cause register access and events
        wr(`ADDR_RESET_CAUSE, 8'hFF);
        rd(`ADDR_RESET_CAUSE, 8'h9F);
        wr(`ADDR_RESET_CAUSE, 8'h00);
        rd(`ADDR_RESET_CAUSE, 8'h0C);
        pulse(5'h04);
        rd(`ADDR_RESET_CAUSE, 8'h08);
        pulse(5'h08);
        rd(`ADDR_RESET_CAUSE, 8'h0C);
        pulse(5'h02);
        wr(`ADDR_RESET_CAUSE, 8'h13);
        rd(`ADDR_RESET_CAUSE, 8'h17);
        pulse(5'h01);
        pulse(5'h10);
        AVS_BYTEENABLE <= 4'hE;
        wr(`ADDR_RESET_CAUSE, 8'h80);
        AVS_BYTEENABLE <= 4'hF;
        rd(`ADDR_RESET_CAUSE, 8'h06);
        wr(`ADDR_RESET_CAUSE, 8'h80);
        $display("cause test done");
        // External pins, both edges, both priorities on pins 1 to 3
        for (i = 0; i < 4; i = i + 1) begin
            for (p = 0; p < 2; p = p + 1) begin
                en = (i == 0) ? 8'h10 : 8'h04 << i;
                fl = (i == 0) ? 8'h02 : 8'h01 << (i - 1);
                sec = (p ? 8'h40 >> i : 8'h00) | {6'h00, i == 3 && p, 1'b0};
                thr = (i == 1 && p) ? 8'h40 : (i == 2 && p) ? 8'h80 : 8'h00;
                ra = i ? `ADDR_CTRL_THIRD : `ADDR_CTRL_MAIN;
                bv = i ? thr : 8'hC0;
                ex = (i == 0 || p) ? 3'b101 : 3'b011;
                wr(`ADDR_CTRL_SECOND, sec);
                EXT_PIN[i] <= !p;
                repeat (4) @(posedge CLK);
                wr(`ADDR_CTRL_MAIN, 8'hC0);
                wr(`ADDR_CTRL_THIRD, thr);
                EXT_PIN[i] <= p;
                irq(3'b000);
                rd(ra, bv | fl);
                wr(ra, bv | en | fl);
                irq(ex);
                wr(`ADDR_CTRL_MAIN, i ? 8'hC0 : 8'hD0);
                wr(`ADDR_CTRL_THIRD, i ? thr | en : thr);
                EXT_PIN[i] <= !p;
                irq(3'b000);
                rd(ra, bv | en);
                wr(`ADDR_CTRL_MAIN, 8'hC0);
                wr(`ADDR_CTRL_THIRD, 8'h00);
            end
        end
        $display("pin test done");
        // Timer overflow, both widths
        wr(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_TIMER_LOW, 8'hFD);
        wr(`ADDR_TIMER_CTRL, 8'hC0);
        wr(`ADDR_CTRL_MAIN, 8'hE0);
        irq(3'b011);
        rd(`ADDR_CTRL_MAIN, 8'hE4);
        wr(`ADDR_CTRL_SECOND, 8'h04);
        irq(3'b101);
        wr(`ADDR_CTRL_SECOND, 8'h00);
        wr(`ADDR_RESET_CAUSE, 8'h00);
        irq(3'b101);
        wr(`ADDR_RESET_CAUSE, 8'h80);
        wr(`ADDR_CTRL_MAIN, 8'hC4);
        irq(3'b000);
        wr(`ADDR_TIMER_CTRL, 8'h00);
        wr(`ADDR_TIMER_HIGH, 8'h00);
        wr(`ADDR_TIMER_LOW, 8'hFC);
        wr(`ADDR_CTRL_MAIN, 8'hE0);
        wr(`ADDR_TIMER_CTRL, 8'h80);
        repeat (8) @(posedge CLK);
        irq(3'b000);
        wr(`ADDR_TIMER_CTRL, 8'h00);
        wr(`ADDR_TIMER_HIGH, 8'hFF);
        wr(`ADDR_TIMER_LOW, 8'hFC);
        rd(`ADDR_TIMER_LOW, 8'hFC);
        rd(`ADDR_TIMER_HIGH, 8'hFF);
        wr(`ADDR_TIMER_CTRL, 8'h80);
        repeat (4) @(posedge CLK);
        irq(3'b011);
        wr(`ADDR_TIMER_CTRL, 8'h00);
        $display("timer test done");
        // Change pins, each one
        wr(`ADDR_CTRL_SECOND, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_CTRL_MAIN, 8'hC8);
            irq(3'b000);
            CHANGE_PIN[i] <= ~CHANGE_PIN[i];
            irq(3'b101);
        end
        wr(`ADDR_CTRL_SECOND, 8'h00);
        irq(3'b011);
        $display("change test done");
        // Wake without global enable, then fast entry
        wr(`ADDR_CTRL_MAIN, 8'h12);
        irq(3'b001);
        sleep <= 1'b0;
        wr(`ADDR_CTRL_MAIN, 8'h92);
        irq(3'b000);
        chk(ent_n, 1);
        chk(SHADOW_WORKING_REGISTER, wsave);
        chk(RETURN_PC, psave);
        rd(`ADDR_CTRL_MAIN, 8'h12);
        $display("wake test done");
        // Fill the return stack
        fast <= 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            e0 = ent_n;
            wr(`ADDR_CTRL_MAIN, 8'h92);
            n = 0;
            while (ent_n == e0 && n < 20) begin
                @(posedge CLK);
                n = n + 1;
            end
            chk(STACK_FULL, i >= 30);
        end
        $display("stack test done");
        print_verdict;
    end
endmodule // irq_sources_tb_top
